// file: accr_config_regs.sv
// Channel 3 phase delay and channel 4 input setup and gain registers.
// Assumes a control port on core_clk presenting page, address and strobes.
//
// Contract
// [R1] Channel 3 samples are delayed by the phase code in modulator ticks.
// [R2] Setup bit 7 picks microphone input at zero, line input at one.
// [R3] Setup bits 6-5: differential 0, single-ended 1, others reserved.
// [R4] Setup bit 4: AC coupling at zero, DC at one; resets to DC.
// [R5] Setup bit 3: low swing at zero, high swing at one.
// [R6] Software sets gain and volume for the peak level in high swing.
// [R7] Setup bits 2-1: high SNR 0, high CMRR 2, others reserved.
// [R8] Setup bit 0 enables auto gain, steered by the auto gain setup bit.
// [R9] Software enables auto gain only with AC-coupled input.
// [R10] Gain bits 7-2 give n dB for code n up to 42; above reserved.
// [R11] Setup sits at page 0 address 4B, gain at address 4C.
// [R12] Software never writes reserved codes into the coded fields.

`timescale 1ns/10ps
`default_nettype none

module accr_config_regs #(
  parameter int SAMPLE_W = 4
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  // Register port.
  input wire logic [7:0] reg_page,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Channel 3 modulator stream.
  input wire logic mod_tick,
  input wire logic [SAMPLE_W-1:0] ch3_sample_in,
  output logic [SAMPLE_W-1:0] ch3_sample_out,
  output logic ch3_sample_valid,
  output logic [7:0] ch3_phase_delay_code,
  // Channel 4 front end settings.
  output logic ch4_input_kind,
  output logic [1:0] ch4_input_source,
  output logic ch4_coupling_select,
  output logic ch4_swing_range,
  output logic [1:0] ch4_frontend_tradeoff,
  output logic ch4_auto_gain_enable,
  output logic [5:0] code_a,
  // Auto gain steering.
  input wire logic auto_gain_setup_mode,
  output logic ch4_auto_gain_active,
  // Reserved code flags.
  output logic ch4_source_reserved,
  output logic ch4_tradeoff_reserved,
  output logic code_a_reserved
);

  // ------------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------------
  logic [7:0] ch3_phase_delay;
  logic [7:0] ch4_input_setup;
  logic [7:0] code_a_select;

  // ------------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------------

  // Only page 0 hits; any other page leaves the registers untouched.
  wire logic page_hit;
  wire logic sel_phase;
  wire logic sel_setup;
  wire logic sel_gain;
  wire logic wr_phase;
  wire logic wr_setup;
  wire logic wr_gain;
  assign page_hit = (reg_page == accr_pkg::PAGE_CFG);
  assign sel_phase = page_hit && (reg_addr == accr_pkg::ADDR_CH3_PHASE);
  assign sel_setup = page_hit && (reg_addr == accr_pkg::ADDR_CH4_SETUP);
  assign sel_gain = page_hit && (reg_addr == accr_pkg::ADDR_CODE_A);
  assign wr_phase = reg_wr && sel_phase;
  assign wr_setup = reg_wr && sel_setup; // [R11]
  assign wr_gain = reg_wr && sel_gain; // [R11]

  // Bit 0 of the gain register is read-only zero, so it is never stored.
  wire logic [7:0] gain_wmask;
  assign gain_wmask = {reg_wdata[7:1], 1'b0};

  // Register writes take effect at the edge that sees the strobe.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ch3_phase_delay <= accr_pkg::RST_CH3_PHASE;
      ch4_input_setup <= accr_pkg::RST_CH4_SETUP; // [R4]
      code_a_select <= accr_pkg::RST_CODE_A;
    end else begin
      if (wr_phase) begin
        ch3_phase_delay <= reg_wdata;
      end
      if (wr_setup) begin
        ch4_input_setup <= reg_wdata;
      end
      if (wr_gain) begin
        code_a_select <= gain_wmask;
      end
    end
  end

  // ------------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------------

  // Unmapped addresses and other pages read as zero, with no side effect.
  wire logic [7:0] next_rdata;
  assign next_rdata = sel_phase ? ch3_phase_delay :
                      sel_setup ? ch4_input_setup :
                      sel_gain ? code_a_select : 8'h00;

  // Read data is held from a flip-flop until the next read.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // ------------------------------------------------------------------
  // Channel 4 field decode
  // ------------------------------------------------------------------

  // The analog front end takes these straight from the stored register.
  assign ch4_input_kind = ch4_input_setup[accr_pkg::KIND_BIT]; // [R2]
  assign ch4_input_source =
    ch4_input_setup[accr_pkg::SRC_LSB +: 2]; // [R3]
  assign ch4_coupling_select =
    ch4_input_setup[accr_pkg::COUPLE_BIT]; // [R4]
  assign ch4_swing_range = ch4_input_setup[accr_pkg::SWING_BIT]; // [R5]
  assign ch4_frontend_tradeoff =
    ch4_input_setup[accr_pkg::TRADE_LSB +: 2]; // [R7]
  assign ch4_auto_gain_enable = ch4_input_setup[accr_pkg::AGC_BIT]; // [R8]
  assign code_a = code_a_select[accr_pkg::GAIN_LSB +: 6]; // [R10]
  assign ch3_phase_delay_code = ch3_phase_delay;

  // Auto gain runs only while enabled; its mode comes from the setup bit.
  // Coupling is not checked here: keeping it AC is software's duty.
  assign ch4_auto_gain_active =
    ch4_auto_gain_enable && auto_gain_setup_mode; // [R8] [R9]

  // Reserved codes are flagged rather than remapped, since their effect
  // on the front end is left undefined.
  assign ch4_source_reserved =
    (ch4_input_source != accr_pkg::SRC_DIFF) &&
    (ch4_input_source != accr_pkg::SRC_SINGLE); // [R3] [R12]
  assign ch4_tradeoff_reserved =
    (ch4_frontend_tradeoff != accr_pkg::TRADE_SNR) &&
    (ch4_frontend_tradeoff != accr_pkg::TRADE_CMRR); // [R7] [R12]
  assign code_a_reserved = (code_a > accr_pkg::GAIN_MAX_DB); // [R10]

  // ------------------------------------------------------------------
  // Channel 3 phase delay line
  // ------------------------------------------------------------------

  // A ring of 256 samples lets any code reach back up to 255 ticks.
  // The ring is not cleared at reset, so after a reset or a code change
  // the first samples out may be stale until the ring has refilled.
  logic [SAMPLE_W-1:0] delay_ring [accr_pkg::PHASE_DEPTH];
  logic [7:0] wr_ptr;
  wire logic [7:0] rd_ptr;
  wire logic [SAMPLE_W-1:0] next_sample;
  assign rd_ptr = wr_ptr - ch3_phase_delay; // [R1]
  assign next_sample = (ch3_phase_delay == 8'h00) ?
                       ch3_sample_in : delay_ring[rd_ptr]; // [R1]

  // The ring itself has no reset, which keeps it a plain memory.
  always_ff @(posedge core_clk) begin
    if (mod_tick) begin
      delay_ring[wr_ptr] <= ch3_sample_in;
    end
  end

  // One sample moves in and one moves out on each modulator tick.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wr_ptr <= 8'h00;
      ch3_sample_out <= '0;
      ch3_sample_valid <= 1'b0;
    end else begin
      ch3_sample_valid <= mod_tick;
      if (mod_tick) begin
        wr_ptr <= wr_ptr + 8'h01;
        ch3_sample_out <= next_sample; // [R1]
      end
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------

  // Input of the last tick, and whether that tick ran at code one with no
  // phase write since. Ticks need not come back to back for the check.
  logic [SAMPLE_W-1:0] chk_prev_in;
  logic chk_code_one;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      chk_prev_in <= '0;
      chk_code_one <= 1'b0;
    end else begin
      if (mod_tick) begin
        chk_prev_in <= ch3_sample_in;
      end
      if (wr_phase) begin
        chk_code_one <= 1'b0;
      end else if (mod_tick) begin
        chk_code_one <= (ch3_phase_delay == 8'h01);
      end
    end
  end

  default clocking chk_cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  phase_zero_a: assert property ( // [R1]
    mod_tick && (ch3_phase_delay == 8'h00) |=>
      ch3_sample_valid && (ch3_sample_out == $past(ch3_sample_in)))
    else $error("Code zero did not pass the sample straight through.");

  phase_one_a: assert property ( // [R1]
    mod_tick && chk_code_one |=>
      ch3_sample_out == $past(chk_prev_in))
    else $error("Code one did not delay the sample by one tick.");

  kind_write_a: assert property ( // [R2]
    wr_setup |=> ch4_input_kind == $past(reg_wdata[7]))
    else $error("Input kind did not follow the setup write.");

  source_write_a: assert property ( // [R3]
    wr_setup |=> (ch4_input_source == $past(reg_wdata[6:5])) &&
      (ch4_source_reserved == $past(reg_wdata[6])))
    else $error("Input source or its reserved flag is wrong.");

  coupling_reset_a: assert property ( // [R4]
    @(posedge core_clk) disable iff (1'b0)
    srst |=> ch4_coupling_select && !ch4_auto_gain_enable)
    else $error("Coupling did not reset to DC.");

  swing_write_a: assert property ( // [R5]
    wr_setup |=> ch4_swing_range == $past(reg_wdata[3]))
    else $error("Swing range did not follow the setup write.");

  tradeoff_flag_a: assert property ( // [R7]
    wr_setup |=> ch4_tradeoff_reserved == $past(reg_wdata[1]))
    else $error("Trade-off reserved flag is wrong.");

  auto_gain_off_a: assert property ( // [R8]
    wr_setup && !reg_wdata[0] |=> !ch4_auto_gain_active)
    else $error("Auto gain stayed active after being disabled.");

  gain_write_a: assert property ( // [R10]
    wr_gain |=> (code_a == $past(reg_wdata[7:2])) &&
      (code_a_reserved == ($past(reg_wdata[7:2]) > 6'h2A)))
    else $error("Gain code or its reserved flag is wrong.");

  page_guard_a: assert property ( // [R11]
    reg_wr && (reg_page != 8'h00) |=>
      $stable(ch4_input_setup) && $stable(code_a_select))
    else $error("A write to another page changed channel 4.");

  gain_read_a: assert property ( // [R11]
    reg_rd && sel_gain && !reg_wr |=> reg_rvalid && !reg_rdata[0] &&
      (reg_rdata[7:2] == code_a))
    else $error("Gain register read back wrongly.");

  phase_write_a: assert property ( // [R1]
    wr_phase |=> ch3_phase_delay_code == $past(reg_wdata))
    else $error("Phase code did not follow the phase write.");

  coupling_write_a: assert property ( // [R4]
    wr_setup |=> ch4_coupling_select == $past(reg_wdata[4]))
    else $error("Coupling did not follow the setup write.");

  tradeoff_write_a: assert property ( // [R7]
    wr_setup |=> ch4_frontend_tradeoff == $past(reg_wdata[2:1]))
    else $error("Trade-off code did not follow the setup write.");

  auto_gain_on_a: assert property ( // [R8]
    wr_setup && reg_wdata[0] |=> ch4_auto_gain_enable &&
      (ch4_auto_gain_active == auto_gain_setup_mode))
    else $error("Enabled auto gain did not follow its mode input.");

  gain_spare_a: assert property ( // [R10]
    wr_gain |=> (code_a_select[1] == $past(reg_wdata[1])) &&
      !code_a_select[0])
    else $error("Gain spare bits were not kept as laid out.");

  read_answer_a: assert property ( // [R11]
    reg_rd |=> reg_rvalid)
    else $error("A read got no answer in the following cycle.");

  unmapped_read_a: assert property ( // [R11]
    reg_rd && !sel_phase && !sel_setup && !sel_gain |=>
      reg_rdata == 8'h00)
    else $error("An unmapped read returned nonzero data.");

endmodule : accr_config_regs

`default_nettype wire

// file: accr_pkg.sv
// Constants for the channel 3 phase and channel 4 setup register slice.
// Assumes the control port that owns these registers sits outside.
package accr_pkg;

  // ------------------------------------------------------------------
  // Register placement
  // ------------------------------------------------------------------
  localparam logic [7:0] PAGE_CFG = 8'h00;
  localparam logic [7:0] ADDR_CH3_PHASE = 8'h4A;
  localparam logic [7:0] ADDR_CH4_SETUP = 8'h4B;
  localparam logic [7:0] ADDR_CODE_A = 8'h4C;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] RST_CH3_PHASE = 8'h00;
  localparam logic [7:0] RST_CH4_SETUP = 8'h10;
  localparam logic [7:0] RST_CODE_A = 8'h00;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int KIND_BIT = 7;
  localparam int SRC_LSB = 5;
  localparam int COUPLE_BIT = 4;
  localparam int SWING_BIT = 3;
  localparam int TRADE_LSB = 1;
  localparam int AGC_BIT = 0;
  localparam int GAIN_LSB = 2;
  localparam int GAIN_SPARE_BIT = 1;

  // ------------------------------------------------------------------
  // Field codes and limits
  // ------------------------------------------------------------------
  localparam logic [1:0] SRC_DIFF = 2'h0;
  localparam logic [1:0] SRC_SINGLE = 2'h1;
  localparam logic [1:0] TRADE_SNR = 2'h0;
  localparam logic [1:0] TRADE_CMRR = 2'h2;
  localparam logic [5:0] GAIN_MAX_DB = 6'h2A;
  localparam int PHASE_DEPTH = 256;

endpackage : accr_pkg

// file: adc_channel_config_regs_tb_top.sv
// Self-checking bench for the channel 3 phase and channel 4 setup registers.
// Assumes accr_pkg is compiled first and the design keeps its default width.
`timescale 1ns/10ps
`default_nettype none

module adc_channel_config_regs_tb_top;
  // ------------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------------
  logic core_clk, srst, reg_wr, reg_rd, reg_rvalid, mod_tick, mode;
  logic [7:0] reg_page, reg_addr, reg_wdata, reg_rdata, rd_val;
  logic [3:0] s_in, s_out;
  logic s_valid, kind, couple, swing, agc_en, agc_act, src_rsv, tr_rsv, g_rsv;
  logic [1:0] src, trade;
  logic [7:0] phase;
  logic [5:0] gain;
  int bad_count, checks;

  accr_config_regs u_dut (.core_clk(core_clk), .srst(srst),
    .reg_page(reg_page), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .mod_tick(mod_tick), .ch3_sample_in(s_in),
    .ch3_sample_out(s_out), .ch3_sample_valid(s_valid),
    .ch3_phase_delay_code(phase), .ch4_input_kind(kind),
    .ch4_input_source(src), .ch4_coupling_select(couple),
    .ch4_swing_range(swing), .ch4_frontend_tradeoff(trade),
    .ch4_auto_gain_enable(agc_en), .code_a(gain),
    .auto_gain_setup_mode(mode), .ch4_auto_gain_active(agc_act),
    .ch4_source_reserved(src_rsv), .ch4_tradeoff_reserved(tr_rsv),
    .code_a_reserved(g_rsv));

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  // Narrow values are zero-extended, so one compare serves every field.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                     input string what);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] pg, input logic [7:0] ad,
                    input logic [7:0] d);
    @(posedge core_clk);
    reg_page <= pg;
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // The answer stands right after the edge that takes the strobe, so it is read 1 ns later.
  task automatic rd(input logic [7:0] pg, input logic [7:0] ad);
    @(posedge core_clk);
    reg_page <= pg;
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk({7'h00, reg_rvalid}, 8'h01, "read answer");
    rd_val = reg_rdata;
  endtask

  task automatic test_done;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset;
    rd(8'h00, 8'h4A);
    chk(rd_val, 8'h00, "phase reset");
    rd(8'h00, 8'h4B);
    chk(rd_val, 8'h10, "setup reset");
    rd(8'h00, 8'h4C);
    chk(rd_val, 8'h00, "gain reset");
    chk({7'h00, couple}, 8'h01, "dc default");
    chk({4'h0, s_out}, 8'h00, "sample reset");
    chk({7'h00, s_valid}, 8'h00, "valid reset");
    $display("test reset done");
  endtask

  // Every code of every setup field, reserved ones included, is walked.
  // Reserved codes are written only to see the flags that catch them.
  // Auto gain is only ever enabled together with AC coupling.
  task automatic t_setup;
    logic [7:0] v [12] = '{8'h80, 8'h20, 8'h40, 8'h60, 8'h10, 8'h08,
                           8'h02, 8'h04, 8'h06, 8'h01, 8'h09, 8'hEF};
    for (int i = 0; i < 12; i++) begin
      wr(8'h00, 8'h4B, v[i]);
      if (v[i][3]) begin
        wr(8'h00, 8'h4C, 8'h00);
      end
      mode <= i[1];
      #1;
      chk({7'h00, kind}, {7'h00, v[i][7]}, "kind");
      chk({6'h00, src}, {6'h00, v[i][6:5]}, "source");
      chk({7'h00, src_rsv}, {7'h00, v[i][6]}, "source rsv");
      chk({7'h00, couple}, {7'h00, v[i][4]}, "coupling");
      chk({7'h00, swing}, {7'h00, v[i][3]}, "swing");
      chk({6'h00, trade}, {6'h00, v[i][2:1]}, "tradeoff");
      chk({7'h00, tr_rsv}, {7'h00, v[i][1]}, "tradeoff rsv");
      chk({7'h00, agc_en}, {7'h00, v[i][0]}, "agc enable");
      chk({7'h00, agc_act}, {7'h00, v[i][0] & mode}, "agc active");
      rd(8'h00, 8'h4B);
      chk(rd_val, v[i], "setup readback");
    end
    $display("test setup done");
  endtask

  // Boundary gain codes; bit 0 is read-only zero while bit 1 is kept.
  task automatic t_gain;
    wr(8'h00, 8'h4C, 8'hA8);
    #1;
    chk({2'h0, gain}, 8'h2A, "gain 42");
    chk({7'h00, g_rsv}, 8'h00, "gain 42 ok");
    wr(8'h00, 8'h4C, 8'hAF);
    #1;
    chk({2'h0, gain}, 8'h2B, "gain 43");
    chk({7'h00, g_rsv}, 8'h01, "gain 43 rsv");
    rd(8'h00, 8'h4C);
    chk(rd_val, 8'hAE, "gain readback");
    $display("test gain done");
  endtask

  // A wrong page must not hit, and neighbouring addresses read zero.
  task automatic t_unmapped;
    wr(8'h01, 8'h4B, 8'h00);
    wr(8'h00, 8'h4D, 8'h00);
    rd(8'h00, 8'h4B);
    chk(rd_val, 8'hEF, "page 1 ignored");
    rd(8'h00, 8'h4D);
    chk(rd_val, 8'h00, "unmapped read");
    rd(8'h01, 8'h4C);
    chk(rd_val, 8'h00, "page 1 read");
    $display("test unmapped done");
  endtask

  // Older outputs are stale after a code change, so only settled ticks count.
  task automatic t_phase;
    logic [7:0] codes [3] = '{8'h00, 8'h01, 8'hFF};
    logic [3:0] exp;
    for (int c = 0; c < 3; c++) begin
      wr(8'h00, 8'h4A, codes[c]);
      #1;
      chk(phase, codes[c], "phase code");
      for (int k = 0; k < codes[c] + 6; k++) begin
        @(posedge core_clk);
        mod_tick <= 1'b1;
        s_in <= 4'(k * 7 + 3);
        @(posedge core_clk);
        mod_tick <= 1'b0;
        #1;
        exp = 4'((k - codes[c]) * 7 + 3);
        if (k >= codes[c]) begin
          chk({7'h00, s_valid}, 8'h01, "sample valid");
          chk({4'h0, s_out}, {4'h0, exp}, "delayed sample");
        end
      end
    end
    $display("test phase done");
  endtask

  // ------------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // The run needs about 660 cycles; the limit of 10000 cycles leaves ample margin.
  initial begin
    #80000;
    bad_count++;
    test_done();
  end

  initial begin
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_page = 8'h00;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    mod_tick = 1'b0;
    mode = 1'b0;
    s_in = 4'h0;
    bad_count = 0;
    checks = 0;
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    t_reset();
    t_setup();
    t_gain();
    t_unmapped();
    t_phase();
    // A reset in mid-run must bring back every reset value over what was written.
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    t_reset();
    test_done();
  end
endmodule // adc_channel_config_regs_tb_top

`default_nettype wire
